// [inc/sci_pkg.sv]
/*
 * constants for the per-channel serial interrupt logic: register offsets,
 * field positions, op codes, type codes and priority order.
 * assumes a 32-bit apb slave with one register per aligned word.
 */
// Behaviour
// - armed char count underflow sets its status bit and misc pending on extra char
// - armed sync loss in biphase mode sets status and misc pending after two missing clocks
// - armed rate generator zero count sets its status bit and misc pending
// - writing one unlatches a status bit; a recurring event sets it again at once
// - an unarmed source never sets its status bit
// - clearing an arm bit leaves the status bit as it is
// - read gives under-service in bits 13-8, pending in 5-0, top bits zero
// - set under-service plus clear-both on same type leaves under-service cleared
// - set under-service with that type unselected in clear-both sets it
// - enables read in bits 5-0; op 0x none, 10 clear, 11 set selected enables
// - interrupt request only while master enable is one
// - disable-lower-chain forces chain enable output low
// - no-vector: acknowledge drives no vector nor wait, but still sets under-service
// - vector status field chooses which types modify the vector
// - allowed type returns modified vector with code in bits 3-1, else plain vector
// - vector upper byte read only, bits 15-12 and 8 mirror the lower byte
// - type code names highest pending type regardless of under-service
// - vector read does not depend on the vector status field
// - acknowledge while requesting with chain input high sets winner's under-service
// - an under-service bit blocks requests of its type and all lower types
// - request needs pending, enable, master enable, chain in high, no service at or above its type
package sci_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_MISC_STATUS = 8'h00;
   localparam logic [7:0] OFF_ARM         = 8'h04;
   localparam logic [7:0] OFF_PEND_SVC    = 8'h08;
   localparam logic [7:0] OFF_INT_CTRL    = 8'h0c;
   localparam logic [7:0] OFF_VECTOR      = 8'h10;
   localparam logic [7:0] OFF_CHAN_CMD    = 8'h14;
   // command field of the channel command register, bits 15-11
   localparam int         CMD_LSB         = 11;
   localparam logic [4:0] CMD_RESET_HIGH  = 5'h02;
   // op field positions
   localparam int         SVC_OP_LSB      = 14;
   localparam int         SVC_SEL_LSB     = 8;
   localparam int         PEND_OP_LSB     = 6;
   localparam int         MIE_BIT         = 15;
   localparam int         DLC_BIT         = 14;
   localparam int         NV_BIT          = 13;
   localparam int         VIS_LSB         = 9;
   // op codes
   localparam logic [1:0] OP_CLR          = 2'h2;
   localparam logic [1:0] OP_SET          = 2'h3;
   localparam logic [1:0] OP_CLR_BOTH     = 2'h1;
   // type indices, in order of rising priority; type code is index + 1
   localparam int         T_MISC          = 0;
   localparam int         T_IOP           = 1;
   localparam int         T_TD            = 2;
   localparam int         T_TS            = 3;
   localparam int         T_RD            = 4;
   localparam int         T_RS            = 5;
   localparam int         NTYPES          = 6;
   localparam logic [2:0] CODE_NONE       = 3'h0;
   // reset values
   localparam logic [5:0] TYPES_RST       = 6'h00;
   localparam logic [7:0] BYTE_RST        = 8'h00;
   localparam logic [3:0] NIB_RST         = 4'h0;
endpackage : sci_pkg

// [rtl/sci_prio.sv]
/*
 * fixed priority encoder over the six interrupt types.
 * assumes bit 5 is the highest priority and the type code is index + 1.
 */
`timescale 1ns/10ps
module sci_prio
(
   input  wire logic [5:0] req_in,
   output logic      [5:0] one_hot_out,
   output logic      [2:0] code_out
);
   // scan upward so the highest set bit wins
   always_comb
   begin
      one_hot_out = 6'h00;
      code_out    = sci_pkg::CODE_NONE;
      for (int i = 0; i < sci_pkg::NTYPES; i++)
      begin
         if (req_in[i])
         begin
            one_hot_out = 6'h00;
            one_hot_out[i] = 1'b1;
            code_out = 3'(i + 1);
         end
      end
   end
endmodule : sci_prio

// [rtl/sci_top.sv]
/*
 * per-channel interrupt logic: misc status latches, pending and
 * under-service latches, enables, channel options and the vector.
 * assumes source event inputs are one-cycle pulses synchronous to clk_in,
 * and that the acknowledge input is one pulse per acknowledge cycle.
 */
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module sci_top
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        char_after_zero_in,
   input  wire logic        biphase_mode_in,
   input  wire logic        two_missing_clk_in,
   input  wire logic        rate_gen_one_zero_in,
   input  wire logic        rate_gen_zero_zero_in,
   input  wire logic [3:0]  set_pending_in,
   input  wire logic        chain_enable_in,
   input  wire logic        int_ack_in,
   output logic             irq_out,
   output logic             chain_enable_out,
   output logic             ack_won_out,
   output logic             vector_drive_out,
   output logic      [7:0]  vector_out,
   output logic             wait_drive_out,
   output logic      [5:0]  pending_out
);
   logic [3:0]  misc_status_ff;
   logic [3:0]  misc_recur_ff;
   logic [3:0]  arm_ff;
   logic [5:0]  pending_ff;
   logic [5:0]  service_ff;
   logic [5:0]  enable_ff;
   logic        mie_ff;
   logic        dlc_ff;
   logic        nv_ff;
   logic [3:0]  vis_ff;
   logic [7:0]  vector_ff;
   logic [3:0]  misc_event;
   logic        wr;
   logic        rd;
   logic        hit;
   logic        lo_ok;
   logic        hi_ok;
   logic [5:0]  svc_mask;
   logic [5:0]  type_req;
   logic        any_req;
   logic [5:0]  win_oh;
   logic [2:0]  win_code;
   logic [2:0]  pend_code;
   logic [5:0]  svc_oh;
   logic        vis_ok;
   logic [7:0]  mod_vector;
   logic [31:0] nxt_prdata;
   logic        ack_take;

   // zero-wait apb: every access completes in its first access cycle
   assign wr    = psel_in && penable_in && pwrite_in;
   assign rd    = psel_in && penable_in && !pwrite_in;
   assign lo_ok = pstrb_in[0];
   assign hi_ok = pstrb_in[1];
   assign hit   = (paddr_in == sci_pkg::OFF_MISC_STATUS) || (paddr_in == sci_pkg::OFF_ARM)
               || (paddr_in == sci_pkg::OFF_PEND_SVC) || (paddr_in == sci_pkg::OFF_INT_CTRL)
               || (paddr_in == sci_pkg::OFF_VECTOR) || (paddr_in == sci_pkg::OFF_CHAN_CMD);

   // gated source events; an unarmed source is simply dropped
   assign misc_event[3] = arm_ff[3] && char_after_zero_in;
   assign misc_event[2] = arm_ff[2] && biphase_mode_in && two_missing_clk_in;
   assign misc_event[1] = arm_ff[1] && rate_gen_one_zero_in;
   assign misc_event[0] = arm_ff[0] && rate_gen_zero_zero_in;

   // under-service of a type masks itself and everything below it
   always_comb
   begin
      svc_mask = 6'h00;
      for (int i = 0; i < sci_pkg::NTYPES; i++)
      begin
         for (int j = i; j < sci_pkg::NTYPES; j++)
         begin
            if (service_ff[j])
            begin
               svc_mask[i] = 1'b1;
            end
         end
      end
   end

   assign type_req = pending_ff & enable_ff & ~svc_mask
                   & {6{mie_ff && chain_enable_in}};
   assign any_req  = |type_req;
   assign ack_take = int_ack_in && any_req && chain_enable_in;

   sci_prio u_win
   (
      .req_in      (type_req),
      .one_hot_out (win_oh),
      .code_out    (win_code)
   );

   sci_prio u_pend
   (
      .req_in      (pending_ff),
      .one_hot_out (),
      .code_out    (pend_code)
   );

   sci_prio u_svc
   (
      .req_in      (service_ff),
      .one_hot_out (svc_oh),
      .code_out    ()
   );

   // which winning types may put their code into the vector
   always_comb
   begin
      vis_ok = 1'b0;
      if (vis_ff[3])
      begin
         case (vis_ff[2:0])
            3'h0, 3'h1: vis_ok = 1'b1;
            3'h2:       vis_ok = win_code >= 3'h2;
            3'h3:       vis_ok = win_code >= 3'h3;
            3'h4:       vis_ok = win_code >= 3'h4;
            3'h5:       vis_ok = win_code >= 3'h5;
            3'h6:       vis_ok = win_code == 3'h6;
            default:    vis_ok = 1'b0;
         endcase
      end
   end

   // modified vector: code replaces bits 3-1, the rest mirrors the base
   assign mod_vector = {vector_ff[7:4], pend_code, vector_ff[0]};

   // misc status latches; a recurrence while latched re-sets on unlatch
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         misc_status_ff <= sci_pkg::NIB_RST;
         misc_recur_ff  <= sci_pkg::NIB_RST;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (wr && lo_ok && paddr_in == sci_pkg::OFF_MISC_STATUS && pwdata_in[i])
            begin
               // set wins over clear in the same cycle
               misc_status_ff[i] <= misc_recur_ff[i] || misc_event[i];
               misc_recur_ff[i]  <= 1'b0;
            end
            else if (misc_event[i])
            begin
               misc_status_ff[i] <= 1'b1;
               misc_recur_ff[i]  <= misc_status_ff[i];
            end
         end
      end
   end

   // arm bits; status is never touched here
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         arm_ff <= sci_pkg::NIB_RST;
      end
      else if (wr && lo_ok && paddr_in == sci_pkg::OFF_ARM)
      begin
         arm_ff <= pwdata_in[3:0];
      end
   end

   // pending latches: hardware sets win over software clears
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pending_ff <= sci_pkg::TYPES_RST;
      end
      else
      begin
         logic [5:0] p;
         logic [5:0] sel;
         logic [1:0] op;
         p   = pending_ff;
         sel = pwdata_in[5:0];
         op  = pwdata_in[sci_pkg::PEND_OP_LSB +: 2];
         if (wr && lo_ok && paddr_in == sci_pkg::OFF_PEND_SVC)
         begin
            if (op == sci_pkg::OP_SET)
            begin
               p = p | sel;
            end
            else if (op == sci_pkg::OP_CLR || op == sci_pkg::OP_CLR_BOTH)
            begin
               p = p & ~sel;
            end
         end
         p[sci_pkg::T_MISC] = p[sci_pkg::T_MISC] | (|misc_event);
         p[4:1] = p[4:1] | set_pending_in;
         pending_ff <= p;
      end
   end

   // under-service latches: ack, software ops, reset-highest command
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         service_ff <= sci_pkg::TYPES_RST;
      end
      else
      begin
         logic [5:0] s;
         logic [1:0] op;
         s  = service_ff;
         op = pwdata_in[sci_pkg::SVC_OP_LSB +: 2];
         if (wr && paddr_in == sci_pkg::OFF_PEND_SVC)
         begin
            // upper byte first so a clear-both in the lower byte overrides it
            if (hi_ok && op == sci_pkg::OP_SET)
            begin
               s = s | pwdata_in[13:8];
            end
            else if (hi_ok && op == sci_pkg::OP_CLR)
            begin
               s = s & ~pwdata_in[13:8];
            end
            if (lo_ok && pwdata_in[sci_pkg::PEND_OP_LSB +: 2] == sci_pkg::OP_CLR_BOTH)
            begin
               s = s & ~pwdata_in[5:0];
            end
         end
         if (wr && hi_ok && paddr_in == sci_pkg::OFF_CHAN_CMD
             && pwdata_in[sci_pkg::CMD_LSB +: 5] == sci_pkg::CMD_RESET_HIGH)
         begin
            s = s & ~svc_oh;
         end
         if (ack_take)
         begin
            s = s | win_oh;
         end
         service_ff <= s;
      end
   end

   // enables and channel options
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         enable_ff <= sci_pkg::TYPES_RST;
         mie_ff    <= 1'b0;
         dlc_ff    <= 1'b0;
         nv_ff     <= 1'b0;
         vis_ff    <= sci_pkg::NIB_RST;
      end
      else if (wr && paddr_in == sci_pkg::OFF_INT_CTRL)
      begin
         if (lo_ok && pwdata_in[sci_pkg::PEND_OP_LSB +: 2] == sci_pkg::OP_SET)
         begin
            enable_ff <= enable_ff | pwdata_in[5:0];
         end
         else if (lo_ok && pwdata_in[sci_pkg::PEND_OP_LSB +: 2] == sci_pkg::OP_CLR)
         begin
            enable_ff <= enable_ff & ~pwdata_in[5:0];
         end
         if (hi_ok)
         begin
            mie_ff <= pwdata_in[sci_pkg::MIE_BIT];
            dlc_ff <= pwdata_in[sci_pkg::DLC_BIT];
            nv_ff  <= pwdata_in[sci_pkg::NV_BIT];
            vis_ff <= pwdata_in[sci_pkg::VIS_LSB +: 4];
         end
      end
   end

   // base vector; the upper byte is derived, so writes to it go nowhere
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         vector_ff <= sci_pkg::BYTE_RST;
      end
      else if (wr && lo_ok && paddr_in == sci_pkg::OFF_VECTOR)
      begin
         vector_ff <= pwdata_in[7:0];
      end
   end

   // read mux
   always_comb
   begin
      nxt_prdata = 32'h0000_0000;
      if (paddr_in == sci_pkg::OFF_MISC_STATUS)
      begin
         nxt_prdata[3:0] = misc_status_ff;
      end
      else if (paddr_in == sci_pkg::OFF_ARM)
      begin
         nxt_prdata[3:0] = arm_ff;
      end
      else if (paddr_in == sci_pkg::OFF_PEND_SVC)
      begin
         nxt_prdata[15:0] = {2'h0, service_ff, 2'h0, pending_ff};
      end
      else if (paddr_in == sci_pkg::OFF_INT_CTRL)
      begin
         nxt_prdata[15:0] = {mie_ff, dlc_ff, nv_ff, vis_ff, 1'b0, 2'h0, enable_ff};
      end
      else if (paddr_in == sci_pkg::OFF_VECTOR)
      begin
         nxt_prdata[15:0] = {mod_vector, vector_ff};
      end
   end

   // apb answer registered: pready rises at the start of the access phase, one cycle after setup
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end
      else
      begin
         pready_out  <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !hit;
         prdata_out  <= (psel_in && !penable_in && !pwrite_in) ? nxt_prdata : 32'h0000_0000;
      end
   end

   // chain and acknowledge outputs, all registered
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         irq_out          <= 1'b0;
         chain_enable_out <= 1'b0;
         ack_won_out      <= 1'b0;
         vector_drive_out <= 1'b0;
         wait_drive_out   <= 1'b0;
         vector_out       <= sci_pkg::BYTE_RST;
         pending_out      <= sci_pkg::TYPES_RST;
      end
      else
      begin
         irq_out <= any_req;
         // a pending request here also blocks the chain below
         chain_enable_out <= chain_enable_in && !dlc_ff && !any_req && !(|service_ff);
         ack_won_out      <= ack_take;
         vector_drive_out <= ack_take && !nv_ff;
         wait_drive_out   <= ack_take && !nv_ff;
         vector_out <= vis_ok ? {vector_ff[7:4], win_code, vector_ff[0]} : vector_ff;
         pending_out <= pending_ff;
      end
   end
endmodule : sci_top

// [tb/sci_checker.sv]
/* port checker for the channel interrupt logic.
   assumes one clock, active-low reset, apb answer one cycle after setup. */
`timescale 1ns/10ps
module sci_checker
(
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        chain_enable_in,
   input wire logic        int_ack_in,
   input wire logic        irq_out,
   input wire logic        ack_won_out,
   input wire logic        vector_drive_out,
   input wire logic        wait_drive_out,
   input wire logic [5:0]  pending_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // highest pending type; bit 5 wins, code is index plus one
   function automatic logic [2:0] top_code(input logic [5:0] p);
      top_code = 3'h0;
      for (int i = 0; i < 6; i++)
         if (p[i])
            top_code = 3'(i + 1);
   endfunction : top_code
   // read setup to one address, then its answer cycle
   sequence read_of(logic [7:0] a);
      psel_in && !penable_in && !pwrite_in && paddr_in == a ##1 pready_out;
   endsequence
   irq_chain_a: assert property (irq_out |-> $past(chain_enable_in))
      else $error("request without chain enable");
   irq_pend_a: assert property
      (irq_out |-> pending_out != 6'h00 || $past(pending_out) != 6'h00)
      else $error("request with nothing pending");
   ack_win_a: assert property
      (ack_won_out |-> $past(int_ack_in) && $past(chain_enable_in))
      else $error("ack won without ack or chain enable");
   vec_drive_a: assert property
      ((vector_drive_out || wait_drive_out)
       |-> ack_won_out && vector_drive_out == wait_drive_out)
      else $error("vector or wait driven outside a won ack");
   svc_read_a: assert property
      (read_of(sci_pkg::OFF_PEND_SVC)
       |-> prdata_out[15:14] == 2'h0 && prdata_out[7:6] == 2'h0)
      else $error("service register top bits not zero");
   en_read_a: assert property
      (read_of(sci_pkg::OFF_INT_CTRL) |-> prdata_out[7:6] == 2'h0)
      else $error("enable op bits not zero");
   vec_mirror_a: assert property
      (read_of(sci_pkg::OFF_VECTOR)
       |-> prdata_out[15:12] == prdata_out[7:4] && prdata_out[8] == prdata_out[0])
      else $error("vector upper byte not mirrored");
   type_code_a: assert property
      (read_of(sci_pkg::OFF_VECTOR) ##0 $stable(pending_out)
       |-> prdata_out[11:9] == top_code(pending_out))
      else $error("type code not highest pending");
endmodule : sci_checker

bind sci_top sci_checker sci_checker_inst
(
   .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .chain_enable_in(chain_enable_in), .int_ack_in(int_ack_in),
   .irq_out(irq_out), .ack_won_out(ack_won_out), .vector_drive_out(vector_drive_out),
   .wait_drive_out(wait_drive_out), .pending_out(pending_out)
);

// [tb/sci_host_model.sv]
/* host acknowledge source and upstream chain neighbour.
   assumes the bench asks for one acknowledge cycle at a time. */
`timescale 1ns/10ps
module sci_host_model
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic ack_req_in,
   input  wire logic up_busy_in,
   output logic      int_ack_out,
   output logic      chain_enable_out
);
   // upstream device holds its chain output low while it is busy itself
   assign chain_enable_out = !up_busy_in;
   // one-cycle ack pulse; never two back to back, as a real host would not
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         int_ack_out <= 1'b0;
      else
         int_ack_out <= ack_req_in && !int_ack_out;
   end
endmodule : sci_host_model

// [tb/sci_top_test.sv]
/* self-checking bench for the channel interrupt logic over apb.
   assumes zero or more apb wait states and the host model for acks. */
`timescale 1ns/10ps
module sci_top_test;
   logic        clk_in, rst_n_in, psel, penable, pwrite, biphase, ack_req, up_busy;
   logic        pready, pslverr, irq, ch_in, ch_out, int_ack, won, vdrv, wdrv, got, rerr;
   logic [7:0]  paddr, vec;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  misc_ev, hw_pend;
   logic [5:0]  pend;
   logic [9:0]  cap;
   logic [47:0] tbl [15];
   int          err_count, samples_checked, i, t, v;

   sci_top sci_top_inst
   (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'h3),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .char_after_zero_in(misc_ev[3]), .biphase_mode_in(biphase),
      .two_missing_clk_in(misc_ev[2]), .rate_gen_one_zero_in(misc_ev[1]),
      .rate_gen_zero_zero_in(misc_ev[0]), .set_pending_in(hw_pend),
      .chain_enable_in(ch_in), .int_ack_in(int_ack), .irq_out(irq),
      .chain_enable_out(ch_out), .ack_won_out(won), .vector_drive_out(vdrv),
      .vector_out(vec), .wait_drive_out(wdrv), .pending_out(pend)
   );
   sci_host_model sci_host_model_inst
   (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .ack_req_in(ack_req),
      .up_busy_in(up_busy), .int_ack_out(int_ack), .chain_enable_out(ch_in)
   );

   initial
   begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer; request held until pready is seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1)
         @(posedge clk_in);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic pulse(input logic [3:0] m, input logic [3:0] h);
      @(posedge clk_in);
      misc_ev <= m;
      hw_pend <= h;
      @(posedge clk_in);
      misc_ev <= 4'h0;
      hw_pend <= 4'h0;
   endtask : pulse

   // request lags its cause by one edge; three edges leave margin
   task automatic settle;
      repeat (3) @(posedge clk_in);
   endtask : settle

   // one acknowledge cycle; captures drive flags and vector when won
   task automatic ack;
      @(posedge clk_in);
      ack_req <= 1'b1;
      @(posedge clk_in);
      ack_req <= 1'b0;
      got = 1'b0;
      repeat (4)
      begin
         @(posedge clk_in);
         if (won === 1'b1)
         begin
            got = 1'b1;
            cap = {vdrv, wdrv, vec};
         end
      end
   endtask : ack

   function automatic logic [7:0] exp_vec(input int vs, input int ty);
      logic [2:0] thr;
      logic [7:0] b;
      thr = (vs[2:0] < 3'h2) ? 3'h0 : vs[2:0] - 3'h1;
      b = 8'h5a;
      if (vs[3] && vs != 15 && ty >= int'(thr))
         b[3:1] = 3'(ty + 1);
      return b;
   endfunction : exp_vec

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   // watchdog: the tests need well under 10000 cycles
   initial
   begin
      repeat (20000) @(posedge clk_in);
      err_count++;
      close_out;
   end

   initial
   begin
      {psel, penable, pwrite, biphase, ack_req, up_busy} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      misc_ev = 4'h0;
      hw_pend = 4'h0;
      err_count = 0;
      samples_checked = 0;
      // waddr, wdata, raddr, expected read
      tbl = '{48'h08_007f_08_0000, 48'h08_00ff_08_003f, 48'h08_ff00_08_3f3f,
              48'h08_8100_08_3e3f, 48'h08_4100_08_3e3f, 48'h08_0082_08_3e3d,
              48'h08_0044_08_3a39, 48'h08_ff41_08_3e38, 48'h08_003f_08_3e38,
              48'h14_1000_08_1e38, 48'h0c_00ff_0c_003f, 48'h0c_0081_0c_003e,
              48'h0c_0041_0c_003e, 48'h0c_00bf_0c_0000, 48'h08_007f_08_0000};
      rst_n_in = 1'b0;
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      xfer(1'b0, sci_pkg::OFF_PEND_SVC, 32'h0);
      check(rd, 32'h0);
      check(ch_out, 1'b1);
      xfer(1'b0, 8'h20, 32'h0);
      check({rerr, rd}, {1'b1, 32'h0});
      $display("test reset done");
      biphase <= 1'b1;
      xfer(1'b1, sci_pkg::OFF_ARM, 32'hf);
      for (i = 0; i < 4; i++)
      begin
         pulse(4'(1 << i), 4'h0);
         xfer(1'b0, sci_pkg::OFF_MISC_STATUS, 32'h0);
         check(rd, 32'((2 << i) - 1));
      end
      check(pend, 6'h01);
      pulse(4'h1, 4'h0);
      xfer(1'b1, sci_pkg::OFF_MISC_STATUS, 32'hf);
      xfer(1'b0, sci_pkg::OFF_MISC_STATUS, 32'h0);
      check(rd, 32'h1);
      xfer(1'b1, sci_pkg::OFF_MISC_STATUS, 32'h1);
      biphase <= 1'b0;
      pulse(4'h4, 4'h0);
      xfer(1'b0, sci_pkg::OFF_MISC_STATUS, 32'h0);
      check(rd, 32'h0);
      pulse(4'h2, 4'h0);
      xfer(1'b1, sci_pkg::OFF_ARM, 32'h0);
      pulse(4'hf, 4'h0);
      xfer(1'b0, sci_pkg::OFF_MISC_STATUS, 32'h0);
      check(rd, 32'h2);
      xfer(1'b1, sci_pkg::OFF_MISC_STATUS, 32'hf);
      $display("test misc done");
      for (i = 0; i < 15; i++)
      begin
         xfer(1'b1, tbl[i][47:40], {16'h0, tbl[i][39:24]});
         xfer(1'b0, tbl[i][23:16], 32'h0);
         check(rd, {16'h0, tbl[i][15:0]});
      end
      $display("test ops done");
      xfer(1'b1, sci_pkg::OFF_INT_CTRL, 32'h40ff);
      settle;
      check(ch_out, 1'b0);
      xfer(1'b1, sci_pkg::OFF_INT_CTRL, 32'h0000);
      pulse(4'h0, 4'h1);
      settle;
      check({irq, pend}, {1'b0, 6'h02});
      xfer(1'b1, sci_pkg::OFF_INT_CTRL, 32'h8000);
      settle;
      check(irq, 1'b1);
      up_busy <= 1'b1;
      settle;
      check(irq, 1'b0);
      ack;
      check(got, 1'b0);
      up_busy <= 1'b0;
      xfer(1'b1, sci_pkg::OFF_VECTOR, 32'hff5a);
      xfer(1'b1, sci_pkg::OFF_PEND_SVC, 32'he0e0);
      settle;
      check(irq, 1'b0);
      xfer(1'b0, sci_pkg::OFF_VECTOR, 32'h0);
      check(rd, 32'h5c5a);
      xfer(1'b1, sci_pkg::OFF_PEND_SVC, 32'ha000);
      settle;
      ack;
      check({got, cap}, {1'b1, 2'b11, 8'h5a});
      xfer(1'b0, sci_pkg::OFF_PEND_SVC, 32'h0);
      check(rd, 32'h2022);
      $display("test chain done");
      for (v = 0; v < 16; v++)
         for (t = 0; t < 6; t++)
         begin
            xfer(1'b1, sci_pkg::OFF_PEND_SVC, 32'h007f);
            xfer(1'b1, sci_pkg::OFF_INT_CTRL, 32'(32'h8000 | (v << 9) | ((v == 7) << 13)));
            xfer(1'b1, sci_pkg::OFF_PEND_SVC, 32'(32'h00c0 | (1 << t)));
            settle;
            ack;
            check({got, cap[9:8]}, {1'b1, (v == 7) ? 2'b00 : 2'b11});
            if (v != 7)
               check(cap[7:0], exp_vec(v, t));
            // vector read must name the pending type whatever the status field holds
            xfer(1'b0, sci_pkg::OFF_VECTOR, 32'h0);
            check(rd, {16'h0, 4'h5, 3'(t + 1), 9'h05a});
            xfer(1'b0, sci_pkg::OFF_PEND_SVC, 32'h0);
            check(rd, 32'(32'h0101 << t));
         end
      $display("test vector done");
      close_out;
   end
endmodule : sci_top_test
